/* bench/panel_process_image_mapper_tb.sv */
// Purpose: Self-checking bench for ppim_mapper
// Assumes: Flash half period shortened to 4 cycles
// Notes:   Inputs change at the falling edge
`timescale 1ns/1ps
`default_nettype none
module panel_process_image_mapper_tb;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [31:0] key_pins = 32'h0;
  logic [15:0] digital_input_pins = 16'h0;
  logic [1:0]  led_both_cfg = 2'h0;
  logic [47:0] in_image;
  logic [95:0] out_image;
  logic [31:0] led_red, led_green;
  logic [15:0] digital_output;
  logic [15:0] fs_output;
  int          n_errors = 0;
  int          checked = 0;
  always #5 core_clk = ~core_clk;
  ppim_mapper #(.FAST_HALF_CYC(4)) ppim_mapper_i (.core_clk(core_clk), .resetn(resetn),
    .key_pins(key_pins), .digital_input_pins(digital_input_pins),
    .led_both_cfg(led_both_cfg), .in_image(in_image), .out_image(out_image),
    .led_red(led_red), .led_green(led_green), .digital_output(digital_output));
  // Fail-safe variant on the same image, outputs 9 to 16 must stay off
  ppim_mapper #(.FAST_HALF_CYC(4), .FAILSAFE_VARIANT(1'b1)) ppim_mapper_fs_i (
    .core_clk(core_clk), .resetn(resetn), .key_pins(key_pins),
    .digital_input_pins(digital_input_pins), .led_both_cfg(led_both_cfg),
    .in_image(), .out_image(out_image), .led_red(), .led_green(),
    .digital_output(fs_output));
  ppim_ctrl_model ppim_ctrl_model_i (.core_clk(core_clk), .out_image(out_image));
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic t_inputs();
    key_pins = 32'h8000_0181;
    digital_input_pins = 16'h8101;
    cyc(5);
    chk("in_image", {16'h8101, 32'h8000_0181}, in_image);
    $display("inputs done");
  endtask
  task automatic t_leds();
    led_both_cfg = 2'h1;
    ppim_ctrl_model_i.set_led(0, 2'b10);
    ppim_ctrl_model_i.set_led(31, 2'b01);
    ppim_ctrl_model_i.set_led(16, 2'b11);
    cyc(4);
    chk("led_red", {16'h0, 32'h0001_0001}, {16'h0, led_red});
    chk("led_green", {16'h0, 32'h8001_0000}, {16'h0, led_green});
    $display("leds done");
  endtask
  task automatic t_cfg();
    logic [3:0] acc;
    for (int c = 0; c < 4; c++) begin
      led_both_cfg = 2'(c);
      cyc(4);
      acc = 4'h5;
      repeat (32) begin
        @(negedge core_clk);
        acc = acc | {led_red[16], 1'b0, led_green[16], 1'b0};
        acc = acc & {1'b1, led_red[16], 1'b1, led_green[16]};
      end
      chk("cfg_led", {32'h0, 16'h8af2 >> (4*c)} & 48'hf, {44'h0, acc});
    end
    $display("cfg done");
  endtask
  task automatic t_outputs();
    int nf;
    int ns;
    logic [15:0] p;
    logic [1:0] st;
    logic [7:0] fs_hi;
    fs_hi = 8'h0;
    nf = 0;
    ns = 0;
    st = 2'b10;
    ppim_ctrl_model_i.set_do(0, 2'b10);
    ppim_ctrl_model_i.set_do(15, 2'b01);
    ppim_ctrl_model_i.set_do(8, 2'b11);
    cyc(4);
    p = digital_output;
    repeat (64) begin
      @(negedge core_clk);
      nf += int'(p[15] !== digital_output[15]);
      ns += int'(p[8] !== digital_output[8]);
      st = st & {digital_output[0], 1'b1} | {1'b0, digital_output[7]};
      fs_hi = fs_hi | fs_output[15:8];
      p = digital_output;
    end
    chk("fast_edges", 48'd16, 48'(nf));
    chk("slow_edges", 48'd4, 48'(ns));
    chk("on_off", 48'h2, {46'h0, st});
    chk("fs_upper_off", 48'h0, {40'h0, fs_hi});
    chk("fs_first_on", 48'h1, {47'h0, fs_output[0]});
    $display("outputs done");
  endtask
  initial begin
    cyc(12);
    resetn = 1'b1;
    cyc(2);
    t_inputs();
    t_leds();
    t_cfg();
    t_outputs();
    final_report();
  end
  initial begin
    #20us;
    n_errors++;
    final_report();
  end
endmodule // panel_process_image_mapper_tb
`default_nettype wire

/* bench/ppim_assertions.sv */
// Purpose: Port checks for ppim_mapper
// Assumes: Standard variant
// Notes:   Checks start four cycles after reset
`timescale 1ns/1ps
`default_nettype none
module ppim_chk (
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic [31:0] key_pins,
  input wire logic [15:0] digital_input_pins,
  input wire logic [1:0]  led_both_cfg,
  input wire logic [47:0] in_image,
  input wire logic [95:0] out_image,
  input wire logic [31:0] led_red,
  input wire logic [31:0] led_green,
  input wire logic [15:0] digital_output
);
  logic [31:0] rb, gb;
  logic [15:0] d1, d2;
  logic [2:0]  up_q = 3'h0;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn || up_q < 3'h4);
  // Cycles since reset release
  always_ff @(posedge core_clk) up_q <= !resetn ? 3'h0 : up_q + {2'h0, up_q != 3'h7};
  // Red and green bits per LED
  for (genvar i = 0; i < 32; i++) begin : g_led
    assign rb[i] = out_image[16*(i/8) + i%8];
    assign gb[i] = out_image[16*(i/8) + 8 + i%8];
  end
  assign d1 = {out_image[87:80], out_image[71:64]};
  assign d2 = {out_image[95:88], out_image[79:72]};
  a_key_map: assert property (in_image[31:0] == $past(key_pins, 3))
    else $error("key bytes wrong");
  a_input_map: assert property (in_image[47:32] == $past(digital_input_pins, 3))
    else $error("input bytes wrong");
  a_red_only: assert property (($past(rb & ~gb) & ~(led_red & ~led_green)) == 32'h0)
    else $error("red code wrong");
  a_green_only: assert property (($past(~rb & gb) & ~(~led_red & led_green)) == 32'h0)
    else $error("green code wrong");
  a_led_off: assert property (($past(~rb & ~gb) & (led_red | led_green)) == 32'h0)
    else $error("off code lit");
  a_both_yellow: assert property ($past(led_both_cfg, 2) == 2'h1
    && $past(led_both_cfg) == 2'h1
    |-> ($past(rb & gb) & ~(led_red & led_green)) == 32'h0) else $error("yellow wrong");
  a_green_no_red: assert property ($past(led_both_cfg, 2) == 2'h0
    && $past(led_both_cfg) == 2'h0
    |-> ($past(rb & gb) & led_red) == 32'h0) else $error("flash green shows red");
  a_out_on: assert property (($past(d1 & ~d2) & ~digital_output) == 16'h0)
    else $error("output not on");
  a_out_off: assert property (($past(~d1 & ~d2) & digital_output) == 16'h0)
    else $error("output not off");
  c_yellow: cover property (led_red[16] && led_green[16]);
  c_fast: cover property ($rose(digital_output[15]));
  c_key: cover property (in_image[31]);
endmodule // ppim_chk
bind ppim_mapper ppim_chk ppim_chk_i (.core_clk(core_clk), .resetn(resetn),
  .key_pins(key_pins), .digital_input_pins(digital_input_pins),
  .led_both_cfg(led_both_cfg), .in_image(in_image), .out_image(out_image),
  .led_red(led_red), .led_green(led_green), .digital_output(digital_output));
`default_nettype wire

/* bench/ppim_ctrl_model.sv */
// Purpose: Controller side writing the output image
// Assumes: Bytes change at the falling edge
// Notes:   Input image is read by the bench
`timescale 1ns/1ps
`default_nettype none
module ppim_ctrl_model (
  input  wire logic   core_clk,
  output var  logic [95:0] out_image
);
  initial out_image = 96'h0;
  task automatic set_led(input int l, input logic [1:0] rg);
    @(negedge core_clk);
    out_image[16*(l/8) + l%8] = rg[1];
    out_image[16*(l/8) + 8 + l%8] = rg[0];
  endtask
  // Output code pair
  task automatic set_do(input int o, input logic [1:0] c);
    @(negedge core_clk);
    out_image[64 + 16*(o/8) + o%8] = c[1];
    out_image[72 + 16*(o/8) + o%8] = c[0];
  endtask
endmodule // ppim_ctrl_model
`default_nettype wire

/* shared/ppim_defines.svh */
// Purpose: Constants for the panel process image mapper
// Assumes: 100 MHz core clock
// Notes:   Byte indices are relative to the image start n
`ifndef PPIM_DEFINES_SVH
`define PPIM_DEFINES_SVH

// Input image byte indices
`define PPIM_IN_KEY_BYTE0     0
`define PPIM_IN_DI_BYTE0      4
`define PPIM_IN_BYTES         6
// Output image byte indices
`define PPIM_OUT_LED_BYTE0    0
`define PPIM_OUT_DO_BYTE0     8
`define PPIM_OUT_BYTES        12
// Flash timing
`define PPIM_CLK_HZ           100000000
`define PPIM_FAST_FLASH_MHZ   2000
`define PPIM_SLOW_FLASH_MHZ   500
// Half period cycles, rounded down
`define PPIM_FAST_HALF_CYC    ((`PPIM_CLK_HZ / 2) / (`PPIM_FAST_FLASH_MHZ / 1000))
`define PPIM_SLOW_HALF_CYC    ((`PPIM_CLK_HZ * 2) / 2)
// Slow half period is the fast half period times this ratio
`define PPIM_SLOW_RATIO       4
// Reset value of the configurable LED state
`define PPIM_CFG_RESET        2'h0

`endif

/* shared/ppim_pkg.sv */
// Purpose: Types for the panel process image mapper
// Assumes: Nothing
// Notes:   Codes are fixed; drive logic relies on them
package ppim_pkg;

  // Configurable LED state when both bits are set
  typedef enum logic [1:0] {
    PPIM_CFG_FLASH_GREEN  = 2'b00,
    PPIM_CFG_YELLOW       = 2'b01,
    PPIM_CFG_FLASH_YELLOW = 2'b10,
    PPIM_CFG_FLASH_RED    = 2'b11
  } ppim_led_cfg_t;

  // Digital output drive mode
  typedef enum logic [1:0] {
    PPIM_DO_OFF   = 2'b00,
    PPIM_DO_ON    = 2'b01,
    PPIM_DO_FAST  = 2'b10,
    PPIM_DO_SLOW  = 2'b11
  } ppim_do_mode_t;

endpackage

/* verilog/ppim_flash_gen.sv */
// Purpose: Common 2 Hz and 0.5 Hz flash phases
// Assumes: One clock, synchronous active low reset
// Notes:   Both phases derive from one counter, so stay aligned
`timescale 1ns/1ps
`default_nettype none
`include "ppim_defines.svh"

module ppim_flash_gen #(
  parameter int unsigned HALF_CYC = `PPIM_FAST_HALF_CYC
) (
  input  wire logic core_clk,
  input  wire logic resetn,
  output logic      fast_phase,
  output logic      slow_phase
);

  localparam int unsigned CW = $clog2(HALF_CYC + 1);

  logic [CW-1:0] cnt_q;
  logic [1:0]    div_q;
  logic          fast_q;
  logic          slow_q;

  // Half period divider, 50 percent duty
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cnt_q <= '0;
    end else if (cnt_q == CW'(HALF_CYC - 1)) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  // Fast phase toggles each half period, slow every fourth
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      fast_q <= 1'b1;
      slow_q <= 1'b1;
      div_q  <= 2'h0;
    end else if (cnt_q == CW'(HALF_CYC - 1)) begin
      fast_q <= ~fast_q;
      div_q  <= div_q + 2'h1;
      if (div_q == 2'h3) begin
        slow_q <= ~slow_q;
      end
    end
  end

  assign fast_phase = fast_q;
  assign slow_phase = slow_q;

endmodule // ppim_flash_gen
`default_nettype wire

/* verilog/ppim_mapper.sv */
// Purpose: Map panel keys, inputs, LEDs and outputs to process image bytes
// Assumes: Key and input pins are asynchronous; image bytes are on core_clk
// Notes:   FAILSAFE_VARIANT leaves outputs 9 to 16 off
`timescale 1ns/1ps
`default_nettype none
`include "ppim_defines.svh"

module ppim_mapper
  import ppim_pkg::*;
#(
  parameter int unsigned NUM_KEYS         = 32,
  parameter int unsigned NUM_IN           = 16,
  parameter int unsigned NUM_OUT          = 16,
  parameter bit          FAILSAFE_VARIANT = 1'b0,
  parameter int unsigned FAST_HALF_CYC    = `PPIM_FAST_HALF_CYC
) (
  input  wire logic                  core_clk,
  input  wire logic                  resetn,
  input  wire logic [NUM_KEYS-1:0]   key_pins,
  input  wire logic [NUM_IN-1:0]     digital_input_pins,
  input  wire logic [1:0]            led_both_cfg,
  output logic [8*`PPIM_IN_BYTES-1:0] in_image,
  input  wire logic [8*`PPIM_OUT_BYTES-1:0] out_image,
  output logic [NUM_KEYS-1:0]        led_red,
  output logic [NUM_KEYS-1:0]        led_green,
  output logic [NUM_OUT-1:0]         digital_output
);

  localparam int unsigned IN_W      = NUM_KEYS + NUM_IN;
  localparam int unsigned IMG_IN_W  = 8 * `PPIM_IN_BYTES;
  localparam int unsigned IMG_OUT_W = 8 * `PPIM_OUT_BYTES;
  localparam int unsigned DO_ACTIVE = FAILSAFE_VARIANT ? 8 : NUM_OUT;

  logic [IN_W-1:0]     sync1_q;
  logic [IN_W-1:0]     sync2_q;
  logic [IN_W-1:0]     in_q;
  logic [NUM_KEYS-1:0] red_d;
  logic [NUM_KEYS-1:0] green_d;
  logic [NUM_KEYS-1:0] red_q;
  logic [NUM_KEYS-1:0] green_q;
  logic [NUM_OUT-1:0]  do_d;
  logic [NUM_OUT-1:0]  do_q;
  ppim_led_cfg_t       cfg_q;
  logic                fast_ph;
  logic                slow_ph;

  // Bit from an image byte pair: byte base + 2*(idx/8) + odd, bit idx%8
  function automatic logic pair_bit(input logic [IMG_OUT_W-1:0] img,
                                    input int unsigned          base,
                                    input int unsigned          idx,
                                    input int unsigned          odd);
    pair_bit = img[8 * (base + 2 * (idx / 8) + odd) + (idx % 8)];
  endfunction

  // Keys then inputs, lowest number at bit 0 of its first byte
  function automatic logic [IMG_IN_W-1:0] pack_inputs(input logic [NUM_KEYS-1:0] keys,
                                                      input logic [NUM_IN-1:0]   ins);
    logic [IMG_IN_W-1:0] img;
    img = '0;
    img[8*`PPIM_IN_KEY_BYTE0 +: NUM_KEYS] = keys;
    img[8*`PPIM_IN_DI_BYTE0 +: NUM_IN]    = ins;
    pack_inputs = img;
  endfunction

  // Colour of one LED; bit 1 red, bit 0 green, both lit is yellow
  function automatic logic [1:0] led_colour(input logic          red_bit,
                                            input logic          green_bit,
                                            input ppim_led_cfg_t cfg,
                                            input logic          flash);
    logic [1:0] rg;
    rg = {red_bit, green_bit};
    if (red_bit && green_bit) begin
      unique case (cfg)
        PPIM_CFG_FLASH_GREEN:  rg = {1'b0, flash};
        PPIM_CFG_YELLOW:       rg = 2'b11;
        PPIM_CFG_FLASH_YELLOW: rg = {flash, flash};
        PPIM_CFG_FLASH_RED:    rg = {flash, 1'b0};
      endcase
    end
    led_colour = rg;
  endfunction

  // Drive mode from the pair (first byte bit, second byte bit)
  function automatic ppim_do_mode_t do_mode(input logic first_bit,
                                            input logic second_bit);
    unique case ({first_bit, second_bit})
      2'b10: do_mode = PPIM_DO_ON;
      2'b01: do_mode = PPIM_DO_FAST;
      2'b11: do_mode = PPIM_DO_SLOW;
      2'b00: do_mode = PPIM_DO_OFF;
    endcase
  endfunction

  // Output level for a drive mode and the two flash phases
  function automatic logic do_level(input ppim_do_mode_t mode,
                                    input logic          fast,
                                    input logic          slow);
    logic lvl;
    lvl = 1'b0;
    unique case (mode)
      PPIM_DO_OFF:  lvl = 1'b0;
      PPIM_DO_ON:   lvl = 1'b1;
      PPIM_DO_FAST: lvl = fast;
      PPIM_DO_SLOW: lvl = slow;
    endcase
    do_level = lvl;
  endfunction

  // Shared flash phases
  // one divider
  ppim_flash_gen #(
    .HALF_CYC   (FAST_HALF_CYC)
  ) u_flash (
    .core_clk   (core_clk),
    .resetn     (resetn),
    .fast_phase (fast_ph),
    .slow_phase (slow_ph)
  );

  // Two stage synchroniser on pins
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {digital_input_pins, key_pins};
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      in_q <= '0;
    end else begin
      in_q <= sync2_q;
    end
  end

  assign in_image = pack_inputs(in_q[NUM_KEYS-1:0], in_q[IN_W-1:NUM_KEYS]);

  // Configuration capture
  // default flashing green
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cfg_q <= ppim_led_cfg_t'(`PPIM_CFG_RESET);
    end else begin
      cfg_q <= ppim_led_cfg_t'(led_both_cfg);
    end
  end

  // LED colour decode from byte pairs
  // pair decode
  always_comb begin
    logic [1:0] rg;
    rg      = 2'b00;
    red_d   = '0;
    green_d = '0;
    for (int unsigned i = 0; i < NUM_KEYS; i++) begin
      rg = led_colour(pair_bit(out_image, `PPIM_OUT_LED_BYTE0, i, 0),
                      pair_bit(out_image, `PPIM_OUT_LED_BYTE0, i, 1),
                      cfg_q, fast_ph);
      red_d[i]   = rg[1];
      green_d[i] = rg[0];
    end
  end

  // LED drive registers
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      red_q   <= '0;
      green_q <= '0;
    end else begin
      red_q   <= red_d;
      green_q <= green_d;
    end
  end

  // Digital output decode; outputs past the variant limit stay off
  // pair decode and variant limit
  always_comb begin
    ppim_do_mode_t m;
    m    = PPIM_DO_OFF;
    do_d = '0;
    for (int unsigned i = 0; i < NUM_OUT; i++) begin
      m = do_mode(pair_bit(out_image, `PPIM_OUT_DO_BYTE0, i, 0),
                  pair_bit(out_image, `PPIM_OUT_DO_BYTE0, i, 1));
      if (i < DO_ACTIVE) begin
        do_d[i] = do_level(m, fast_ph, slow_ph);
      end else begin
        do_d[i] = 1'b0;
      end
    end
  end

  // Digital output registers
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      do_q <= '0;
    end else begin
      do_q <= do_d;
    end
  end

  // Drive registers straight to the ports
  assign led_red        = red_q;
  assign led_green      = green_q;
  assign digital_output = do_q;

endmodule // ppim_mapper
`default_nettype wire
